// ### esp_pkg.sv
// Constants shared by the serial port design
package esp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [4:0] IDX_CTRL1 = 5'h10;
   localparam logic [4:0] IDX_MASK  = 5'h11;
   localparam logic [4:0] IDX_CTRL3 = 5'h12;
   localparam logic [4:0] IDX_STAT1 = 5'h13;
   localparam logic [4:0] IDX_STAT2 = 5'h14;
   localparam logic [4:0] IDX_DATA  = 5'h15;
   localparam logic [4:0] IDX_BAUD  = 5'h16;
   localparam logic [4:0] IDX_PRESC = 5'h17;
   // Control one fields
   localparam int C1_INV = 0;
   localparam int C1_M   = 1;
   localparam int C1_TE  = 2;
   localparam int C1_RE  = 3;
   localparam int C1_SBK = 4;
   // Status one and mask fields
   localparam int S_TXE = 0;
   localparam int S_TC  = 1;
   localparam int S_RXF = 2;
   localparam int S_FE  = 3;
   localparam int S_BRK = 4;
   localparam int S_OVR = 5;
   // Other fields
   localparam int C3_R8  = 0;
   localparam int C3_T8  = 1;
   localparam int S2_RPF = 0;
   localparam int B_LIN_BREAK_TRANSMIT_ENABLE = 6;
   // Reset values
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [5:0] RST_MASK  = 6'h00;
   localparam logic [7:0] RST_BAUD  = 8'h00;
   localparam logic [7:0] RST_PRESC = 8'h00;
   // Timing counts in sampling ticks and bits
   localparam logic [3:0] RT_LAST  = 4'hF;
   localparam logic [3:0] RT_MID   = 4'h7;
   localparam logic [3:0] BITS8    = 4'hA;
   localparam logic [3:0] BITS9    = 4'hB;
   localparam logic [3:0] BITS_LIN = 4'hD;
   localparam logic [7:0] IDLE8    = 8'h9F;
   localparam logic [7:0] IDLE9    = 8'hAF;
   typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_PRE, TX_BRK} esp_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} esp_rx_e;
endpackage : esp_pkg

// ### esp_remote_node.sv
// Remote serial node model: sends frames on rxd and decodes txd
`timescale 1ns/100ps
module esp_remote_node (
   input  wire logic sys_clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   int bit_clks = 16;
   initial rxd_o = 1'b1;
   task automatic send(input logic [12:0] bits, input int nb);
      for (int i = 0; i < nb; i++) begin
         rxd_o <= bits[i];
         repeat (bit_clks) @(posedge sys_clk_i);
      end
      rxd_o <= 1'b1;
   endtask : send
   // Start low, data LSB first, stop high
   task automatic recv(input int nb, input logic inv,
                       output logic [8:0] d, output int gap,
                       output logic stp);
      gap = 0;
      d = '0;
      while ((txd_i ^ inv) !== 1'b0 && gap < 4000) begin
         @(posedge sys_clk_i);
         gap++;
      end
      repeat (bit_clks / 2) @(posedge sys_clk_i);
      for (int i = 0; i < nb; i++) begin
         repeat (bit_clks) @(posedge sys_clk_i);
         d[i] = txd_i ^ inv;
      end
      repeat (bit_clks) @(posedge sys_clk_i);
      stp = txd_i ^ inv;
   endtask : recv
endmodule : esp_remote_node

// ### esp_serial_port.sv
// Enhanced asynchronous serial port with Avalon-MM register access
`timescale 1ns/100ps
module esp_serial_port
   import esp_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [6:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        rxd_i,
   output logic             txd_o,
   output logic             irq_o
);

   logic [7:0]  ctrl1_q;
   logic [5:0]  mask_q;
   logic        t8_q;
   logic        r8_q;
   logic [5:0]  stat_q;
   logic        rpf_q;
   logic [7:0]  baud_q;
   logic [7:0]  presc_q;
   logic [7:0]  txbuf_q;
   logic        txfull_q;
   logic [7:0]  rxbuf_q;
   logic        wait_q;
   logic [13:0] div_q;
   logic        tick, req, wr_go;
   logic [4:0]  idx;
   logic [7:0]  wd;
   logic        char9, te, inv;
   esp_tx_e     tx_state_q;
   logic [12:0] tx_sh_q;
   logic [3:0]  tx_rt_q;
   logic [3:0]  tx_left_q;
   logic        te_q, idle_pend_q, tc_prev_q;
   logic        line, start_ok, load_data;
   logic        start_brk, start_pre, tx_done, tc_cond;
   esp_rx_e     rx_state_q;
   logic [3:0]  rx_rt_q;
   logic [3:0]  rx_n_q;
   logic [9:0]  rx_sh_q;
   logic [7:0]  idle_cnt_q;
   logic        rx_done, rx_brk, rx_fe;
   logic [5:0]  ev;
   logic [5:0]  w1c;

   assign req   = avs_read_i | avs_write_i;
   assign idx   = avs_address_i[6:2];
   assign wd    = avs_writedata_i[7:0];
   assign wr_go = avs_write_i & ~wait_q & avs_byteenable_i[0];
   assign char9 = ctrl1_q[C1_M];
   assign te    = ctrl1_q[C1_TE];
   assign inv   = ctrl1_q[C1_INV];

   // Bus handshake: request waits one cycle, taken when waitrequest low
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req & wait_q);
      end
   end

   // Read data prepared while waitrequest is high
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i & wait_q) begin
         avs_readdata_o <= 32'h0;
         unique case (idx)
            IDX_CTRL1: avs_readdata_o[7:0] <= ctrl1_q;
            IDX_MASK:  avs_readdata_o[5:0] <= mask_q;
            IDX_CTRL3: avs_readdata_o[1:0] <= {t8_q, r8_q};
            IDX_STAT1: avs_readdata_o[5:0] <= stat_q;
            IDX_STAT2: avs_readdata_o[0]   <= rpf_q;
            IDX_DATA:  avs_readdata_o[7:0] <= rxbuf_q;
            IDX_BAUD:  avs_readdata_o[7:0] <= baud_q;
            IDX_PRESC: avs_readdata_o[7:0] <= presc_q;
            default:   avs_readdata_o <= 32'h0;
         endcase
      end
   end

   assign avs_waitrequest_o = wait_q;

   // Control registers written by software
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl1_q <= RST_CTRL1;
         mask_q  <= RST_MASK;
         t8_q    <= 1'b0;
         presc_q <= RST_PRESC;
         baud_q  <= RST_BAUD;
      end else if (wr_go) begin
         if (idx == IDX_CTRL1) ctrl1_q <= wd;
         if (idx == IDX_MASK) mask_q <= wd[5:0];
         if (idx == IDX_CTRL3) t8_q <= wd[C3_T8];
         if (idx == IDX_PRESC) presc_q <= wd;
         if (idx == IDX_BAUD) baud_q <= wd;
      end
   end

   assign tick = (div_q >= {presc_q, baud_q[5:0]});

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_q <= 14'h0;
      end else begin
         div_q <= tick ? 14'h0 : div_q + 14'h1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (wr_go && idx == IDX_DATA) txbuf_q <= wd;
   end

   // Transmit buffer full; a new write wins over the handover
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txfull_q <= 1'b0;
      end else if (wr_go && idx == IDX_DATA) begin
         txfull_q <= 1'b1;
      end else if (load_data) begin
         txfull_q <= 1'b0;
      end
   end

   // Next character chosen only between characters
   assign start_ok  = (tx_state_q == TX_IDLE) & tick & te;
   assign start_brk = start_ok & ctrl1_q[C1_SBK];
   assign start_pre = start_ok & ~ctrl1_q[C1_SBK] & idle_pend_q;
   assign load_data = start_ok & ~ctrl1_q[C1_SBK] & ~idle_pend_q
                      & txfull_q;
   assign tx_done   = (tx_state_q != TX_IDLE) & tick
                      & (tx_rt_q == RT_LAST) & (tx_left_q == 4'h1);

   // Transmit shifter
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_state_q <= TX_IDLE;
         tx_sh_q    <= 13'h1FFF;
         tx_rt_q    <= 4'h0;
         tx_left_q  <= 4'h0;
      end else begin
         unique case (tx_state_q)
            TX_IDLE: begin
               tx_rt_q <= 4'h0;
               tx_left_q <= char9 ? BITS9 : BITS8;
               if (start_brk) begin
                  tx_state_q <= TX_BRK;
                  tx_sh_q    <= 13'h0;
                  if (baud_q[B_LIN_BREAK_TRANSMIT_ENABLE]) tx_left_q <= BITS_LIN;
               end else if (start_pre) begin
                  tx_state_q <= TX_PRE;
                  tx_sh_q    <= 13'h1FFF;
               end else if (load_data) begin
                  // start, data LSB first, ninth, stop
                  tx_state_q <= TX_DATA;
                  tx_sh_q <= {3'b111, char9 ? t8_q : 1'b1, txbuf_q, 1'b0};
               end
            end
            default: begin
               // character always runs to its end
               if (tick) begin
                  tx_rt_q <= tx_rt_q + 4'h1;
                  if (tx_rt_q == RT_LAST) begin
                     tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
                     tx_left_q <= tx_left_q - 4'h1;
                     if (tx_done) tx_state_q <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Preamble queued on every enable rising edge
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         te_q        <= 1'b0;
         idle_pend_q <= 1'b0;
      end else begin
         te_q <= te;
         if (te & ~te_q) begin
            idle_pend_q <= 1'b1;
         end else if (start_pre) begin
            idle_pend_q <= 1'b0;
         end
      end
   end

   assign line = (tx_state_q == TX_IDLE) ? 1'b1 : tx_sh_q[0];

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txd_o <= 1'b1;
      end else begin
         txd_o <= line ^ inv;
      end
   end

   // complete when nothing left and nothing generated
   assign tc_cond = (tx_state_q == TX_IDLE) & ~txfull_q & ~idle_pend_q
                    & ~ctrl1_q[C1_SBK];

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tc_prev_q <= 1'b1;
      end else begin
         tc_prev_q <= tc_cond;
      end
   end

   // Receiver, sixteen samples per bit
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_state_q <= RX_IDLE;
         rx_rt_q    <= 4'h0;
         rx_n_q     <= 4'h0;
         rx_sh_q    <= 10'h0;
         idle_cnt_q <= 8'h0;
         rpf_q      <= 1'b0;
      end else if (tick) begin
         unique case (rx_state_q)
            RX_IDLE: begin
               if (ctrl1_q[C1_RE] && !rxd_i) begin
                  rx_state_q <= RX_START;
                  rx_rt_q    <= 4'h1;
                  idle_cnt_q <= 8'h0;
                  rpf_q      <= 1'b1;
               end else if (rxd_i) begin
                  if (idle_cnt_q == (char9 ? IDLE9 : IDLE8)) begin
                     rpf_q <= 1'b0;
                  end else begin
                     idle_cnt_q <= idle_cnt_q + 8'h1;
                  end
               end else begin
                  idle_cnt_q <= 8'h0;
               end
            end
            RX_START: begin
               rx_rt_q <= rx_rt_q + 4'h1;
               rx_n_q  <= 4'h0;
               if (rx_rt_q == RT_MID && rxd_i) begin
                  rx_state_q <= RX_IDLE;
                  rpf_q      <= 1'b0;
               end else if (rx_rt_q == RT_LAST) begin
                  rx_state_q <= RX_DATA;
               end
            end
            default: begin
               rx_rt_q <= rx_rt_q + 4'h1;
               if (rx_rt_q == RT_MID) begin
                  rx_sh_q[rx_n_q] <= rxd_i;
                  rx_n_q <= rx_n_q + 4'h1;
                  if (rx_done) rx_state_q <= RX_IDLE;
               end
            end
         endcase
      end
   end

   assign rx_done = tick & (rx_state_q == RX_DATA) & (rx_rt_q == RT_MID)
                    & (rx_n_q == (char9 ? 4'h9 : 4'h8));
   assign rx_fe   = rx_done & ~rxd_i;
   assign rx_brk  = rx_fe & ~|(rx_sh_q[8:0] & {char9, 8'hFF});

   always_ff @(posedge sys_clk_i) begin
      if (rx_done) rxbuf_q <= rx_brk ? 8'h00 : rx_sh_q[7:0];
   end

   // ninth bit or copy of bit 7
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r8_q <= 1'b0;
      end else if (rx_done) begin
         r8_q <= rx_brk ? 1'b0 : (char9 ? rx_sh_q[8] : rx_sh_q[7]);
      end
   end

   // Sticky events, set wins over write-one-to-clear
   always_comb begin
      ev        = 6'h0;
      ev[S_TXE] = load_data;
      ev[S_TC]  = tc_cond & ~tc_prev_q;
      ev[S_RXF] = rx_done;
      ev[S_FE]  = rx_fe;
      ev[S_BRK] = rx_brk;
      ev[S_OVR] = rx_done & stat_q[S_RXF];
   end

   assign w1c = (wr_go && idx == IDX_STAT1) ? wd[5:0] : 6'h0;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stat_q <= 6'h0;
      end else begin
         stat_q <= (stat_q & ~w1c) | ev;
      end
   end

   // enabled flags only; progress flag excluded
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(stat_q & mask_q);
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   brk_clears_a : assert property (
      rx_brk |=> rxbuf_q == 8'h00 && stat_q[S_FE] && stat_q[S_BRK]
                 && stat_q[S_RXF] && !r8_q)
      else $error("break did not clear data or set flags");
   idle_high_a : assert property (
      (tx_state_q == TX_PRE && !inv) |=> txd_o)
      else $error("idle character bit not high");
   pre_first_a : assert property (
      (start_ok && idle_pend_q && !ctrl1_q[C1_SBK]) |=> tx_state_q == TX_PRE)
      else $error("preamble not sent first");
   te_off_a : assert property (
      (tx_state_q == TX_IDLE && !te) |=> tx_state_q == TX_IDLE)
      else $error("transmit started while disabled");
   invert_a : assert property (
      (tx_state_q == TX_IDLE && inv) |=> !txd_o)
      else $error("inverted idle level wrong");
   tx_empty_a : assert property (
      load_data |=> stat_q[S_TXE] && tx_state_q == TX_DATA
                    ##1 txd_o == inv)
      else $error("handover did not set empty flag");
   tc_cause_a : assert property (
      $rose(stat_q[S_TC]) |-> $past(tx_state_q) == TX_IDLE
                             && !$past(txfull_q) && !$past(idle_pend_q))
      else $error("complete flag without cause");
   irq_mask_a : assert property (
      |(stat_q & mask_q) |=> irq_o)
      else $error("masked interrupt wrong");
   irq_off_a : assert property (
      !(|(stat_q & mask_q)) |=> !irq_o)
      else $error("interrupt without unmasked flag");
   ninth_a : assert property (
      (rx_done && !rx_brk && !char9) |=> r8_q == rxbuf_q[7])
      else $error("ninth bit not copy of bit 7");
   rpf_set_a : assert property (
      (rx_state_q == RX_IDLE && ctrl1_q[C1_RE] && tick && !rxd_i)
      |=> rpf_q ##1 rx_state_q == RX_START)
      else $error("progress flag not set at start");
   bus_ack_a : assert property (
      (req && wait_q) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle");

   tx_data_c : cover property (load_data ##[1:1000] tx_done);
   rx_break_c : cover property (rx_brk);
   false_start_c : cover property (
      rx_state_q == RX_START ##1 rx_state_q == RX_IDLE && !rpf_q);
   irq_c : cover property ($rose(irq_o));

endmodule : esp_serial_port

// ### test_esp_serial_port.sv
// Self-checking testbench for the serial port
`timescale 1ns/100ps
module test_esp_serial_port
   import esp_pkg::*;
();
   logic        sys_clk_i;
   logic        rst_b_i;
   logic [6:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        rxd_i;
   logic        txd_o;
   logic        irq_o;
   int          mismatches = 0;
   int          num_checks = 0;
   logic [8:0]  d;
   int          gap;
   logic        stp;
   int          n_low;

   esp_serial_port u_dut (
      .sys_clk_i         (sys_clk_i),
      .rst_b_i           (rst_b_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .rxd_i             (rxd_i),
      .txd_o             (txd_o),
      .irq_o             (irq_o)
   );

   esp_remote_node u_node (
      .sys_clk_i (sys_clk_i),
      .txd_i     (txd_o),
      .rxd_o     (rxd_i)
   );

   task automatic end_sim();
      $display("Checks made %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [4:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      avs_address_i   <= {idx, 2'b00};
      avs_writedata_i <= {24'h000000, wd};
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) begin
         chk(32'h1, 32'h0);
      end
      rd = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge sys_clk_i);
   endtask : acc

   task automatic wr(input logic [4:0] idx, input logic [7:0] v);
      logic [7:0] t;
      acc(1'b1, idx, v, t);
   endtask : wr

   task automatic rchk(input logic [4:0] idx, input logic [7:0] m,
                       input logic [7:0] e);
      logic [7:0] t;
      acc(1'b0, idx, 8'h00, t);
      chk({24'h000000, t & m}, {24'h000000, e});
   endtask : rchk

   task automatic wait_clks(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : wait_clks

   function automatic logic near(input int g, input int nb);
      int e;
      e = nb * u_node.bit_clks;
      return (g >= e - u_node.bit_clks / 2) && (g <= e + u_node.bit_clks / 4);
   endfunction : near

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      wait_clks(20000);
      mismatches++;
      end_sim();
   end

   initial begin
      rst_b_i = 1'b0;
      avs_address_i = 7'h00;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_writedata_i = 32'h00000000;
      avs_byteenable_i = 4'hF;
      wait_clks(4);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      rchk(IDX_CTRL1, 8'hFF, RST_CTRL1);
      rchk(IDX_BAUD, 8'hFF, RST_BAUD);
      rchk(IDX_STAT2, 8'h01, 8'h00);
      rchk(5'h1F, 8'hFF, 8'h00);
      wr(IDX_BAUD, 8'h40);
      rchk(IDX_BAUD, 8'hFF, 8'h40);
      wr(IDX_BAUD, 8'h00);
      wr(IDX_PRESC, 8'h00);
      $display("Test registers done");
      wr(IDX_MASK, 8'h01 << S_TXE);
      wr(IDX_CTRL1, 8'h01 << C1_TE);
      wr(IDX_DATA, 8'hA5);
      u_node.recv(8, 1'b0, d, gap, stp);
      chk(d, 9'h0A5);
      chk(stp, 1'b1);
      chk(near(gap, 10), 1'b1);
      wait_clks(32);
      rchk(IDX_STAT1, 8'h03, 8'h03);
      wait_clks(2);
      chk(irq_o, 1'b1);
      wr(IDX_MASK, 8'h00);
      wait_clks(2);
      chk(irq_o, 1'b0);
      wr(IDX_MASK, 8'h01 << S_TC);
      wait_clks(2);
      chk(irq_o, 1'b1);
      wr(IDX_STAT1, 8'h3F);
      rchk(IDX_STAT1, 8'h3F, 8'h00);
      chk(irq_o, 1'b0);
      $display("Test transmit done");
      wr(IDX_CTRL1, 8'h01 << C1_RE);
      fork
         u_node.send({1'b1, 8'hC3, 1'b0}, 10);
         begin
            wait_clks(64);
            rchk(IDX_STAT2, 8'h01, 8'h01);
         end
      join
      wait_clks(4);
      rchk(IDX_STAT1, 8'h3C, 8'h04);
      rchk(IDX_DATA, 8'hFF, 8'hC3);
      rchk(IDX_CTRL3, 8'h01, 8'h01);
      wait_clks(200);
      rchk(IDX_STAT2, 8'h01, 8'h00);
      wr(IDX_STAT1, 8'h3F);
      u_node.bit_clks = 4;
      u_node.send(13'h0000, 1);
      rchk(IDX_STAT2, 8'h01, 8'h01);
      wait_clks(8);
      rchk(IDX_STAT2, 8'h01, 8'h00);
      u_node.bit_clks = 16;
      u_node.send(13'h0000, 10);
      wait_clks(4);
      rchk(IDX_STAT1, 8'h1C, 8'h1C);
      rchk(IDX_DATA, 8'hFF, 8'h00);
      rchk(IDX_CTRL3, 8'h01, 8'h00);
      $display("Test receive done");
      wr(IDX_CTRL1, 8'h01 << C1_INV);
      wait_clks(3);
      chk(txd_o, 1'b0);
      wr(IDX_CTRL1, (8'h01 << C1_INV) | (8'h01 << C1_TE));
      wr(IDX_DATA, 8'h5A);
      u_node.recv(8, 1'b1, d, gap, stp);
      chk(d, 9'h05A);
      chk(stp, 1'b1);
      chk(near(gap, 10), 1'b1);
      wait_clks(32);
      wr(IDX_CTRL1, 8'h00);
      $display("Test inversion done");
      wr(IDX_CTRL1, 8'h01 << C1_TE);
      wr(IDX_DATA, 8'h11);
      fork
         u_node.recv(8, 1'b0, d, gap, stp);
         begin
            wait_clks(200);
            wr(IDX_CTRL1, 8'h00);
            wr(IDX_CTRL1, 8'h01 << C1_TE);
            wr(IDX_DATA, 8'h22);
         end
      join
      chk(d, 9'h011);
      chk(stp, 1'b1);
      u_node.recv(8, 1'b0, d, gap, stp);
      chk(gap > 9 * u_node.bit_clks, 1'b1);
      chk(d, 9'h022);
      wait_clks(32);
      $display("Test enable toggle done");
      wr(IDX_CTRL1, 8'h00);
      wr(IDX_BAUD, 8'h01);
      u_node.bit_clks = 32;
      wr(IDX_STAT1, 8'h3F);
      wr(IDX_CTRL3, 8'h01 << C3_T8);
      wr(IDX_CTRL1, (8'h01 << C1_M) | (8'h01 << C1_TE) | (8'h01 << C1_RE));
      wr(IDX_DATA, 8'h3C);
      u_node.recv(9, 1'b0, d, gap, stp);
      chk(d, 9'h13C);
      chk(near(gap, 11), 1'b1);
      u_node.send({1'b1, 9'h1A5, 1'b0}, 11);
      wait_clks(4);
      rchk(IDX_DATA, 8'hFF, 8'hA5);
      rchk(IDX_CTRL3, 8'h01, 8'h01);
      $display("Test nine bit done");
      wr(IDX_BAUD, 8'h40);
      wr(IDX_CTRL1, (8'h01 << C1_TE) | (8'h01 << C1_SBK));
      wr(IDX_CTRL1, 8'h01 << C1_TE);
      n_low = 0;
      while (txd_o === 1'b0 && n_low < 400) begin
         @(posedge sys_clk_i);
         n_low++;
      end
      chk(n_low > 12 * 16 && n_low <= 13 * 16, 1'b1);
      $display("Test break done");
      end_sim();
   end
endmodule : test_esp_serial_port
